/* File: rtl/sdr_lat_pkg.sv */
// Purpose: Shared constants, tables and helpers for the single-data-rate read latency selector
// Assumes: Six read command classes and five clock bands with one row of cycle counts each
// Notes:   A count of UNSUPPORTED in a row means the command may not be used in that band
package sdr_lat_pkg;

	localparam int ROWS = 5;
	localparam int CMDS = 6;

	typedef logic [7:0] byte_t;
	typedef logic [2:0] idx_t;
	typedef logic [1:0] code_t;

	// Read command classes, used as the column index of the tables
	localparam idx_t CMD_READ = 3'h0;
	localparam idx_t CMD_FAST = 3'h1;
	localparam idx_t CMD_DOUT = 3'h2;
	localparam idx_t CMD_QOUT = 3'h3;
	localparam idx_t CMD_DIO  = 3'h4;
	localparam idx_t CMD_QIO  = 3'h5;
	localparam idx_t CMD_NONE = 3'h7;

	// Clock bands, used as the row index of the tables
	localparam idx_t ROW_50  = 3'h0;
	localparam idx_t ROW_80  = 3'h1;
	localparam idx_t ROW_90  = 3'h2;
	localparam idx_t ROW_104 = 3'h3;
	localparam idx_t ROW_133 = 3'h4;

	localparam code_t CODE_50  = 2'h3;
	localparam code_t CODE_80  = 2'h0;
	localparam code_t CODE_90  = 2'h1;
	localparam code_t CODE_104 = 2'h2;

	localparam byte_t UNSUPPORTED = 8'hFF;

	// Band limit in MHz as a plain binary value
	localparam byte_t FREQ_MHZ [ROWS] = '{8'h32, 8'h50, 8'h5A, 8'h68, 8'h85};
	localparam code_t ROW_CODE [ROWS] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h2};

	// Columns: read, fast, dual out, quad out, dual I/O, quad I/O
	localparam byte_t MODE_TBL [ROWS][CMDS] = '{
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02},
		'{8'hFF, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02},
		'{8'hFF, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02},
		'{8'hFF, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02},
		'{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF}};
	localparam byte_t DUMMY_TBL [ROWS][CMDS] = '{
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01},
		'{8'hFF, 8'h08, 8'h08, 8'h08, 8'h00, 8'h04},
		'{8'hFF, 8'h08, 8'h08, 8'h08, 8'h01, 8'h04},
		'{8'hFF, 8'h08, 8'h08, 8'h08, 8'h02, 8'h05},
		'{8'hFF, 8'h08, 8'hFF, 8'hFF, 8'hFF, 8'hFF}};

	// Read opcodes, three- and four-byte address forms
	localparam byte_t OP_READ3 = 8'h03;
	localparam byte_t OP_READ4 = 8'h13;
	localparam byte_t OP_FAST3 = 8'h0B;
	localparam byte_t OP_FAST4 = 8'h0C;
	localparam byte_t OP_DOUT3 = 8'h3B;
	localparam byte_t OP_DOUT4 = 8'h3C;
	localparam byte_t OP_QOUT3 = 8'h6B;
	localparam byte_t OP_QOUT4 = 8'h6C;
	localparam byte_t OP_DIO3  = 8'hBB;
	localparam byte_t OP_DIO4  = 8'hBC;
	localparam byte_t OP_QIO3  = 8'hEB;
	localparam byte_t OP_QIO4  = 8'hEC;

	localparam byte_t ADDR3_BITS  = 8'h18;
	localparam byte_t ADDR4_BITS  = 8'h20;
	localparam int    SHIFT_DUAL  = 1;
	localparam int    SHIFT_QUAD  = 2;
	localparam idx_t  OP_LAST_BIT = 3'h7;

	typedef enum logic [1:0] {L_OPCODE, L_LAT, L_DATA, L_IGNORE} link_state_e;

	function automatic idx_t code_to_row(input code_t code, input logic high_band);
		case (code)
			CODE_50:  code_to_row = ROW_50;
			CODE_80:  code_to_row = ROW_80;
			CODE_90:  code_to_row = ROW_90;
			default:  code_to_row = high_band ? ROW_133 : ROW_104;
		endcase
	endfunction : code_to_row

	function automatic idx_t decode_op(input byte_t op);
		case (op)
			OP_READ3, OP_READ4: decode_op = CMD_READ;
			OP_FAST3, OP_FAST4: decode_op = CMD_FAST;
			OP_DOUT3, OP_DOUT4: decode_op = CMD_DOUT;
			OP_QOUT3, OP_QOUT4: decode_op = CMD_QOUT;
			OP_DIO3, OP_DIO4:   decode_op = CMD_DIO;
			OP_QIO3, OP_QIO4:   decode_op = CMD_QIO;
			default:            decode_op = CMD_NONE;
		endcase
	endfunction : decode_op

	function automatic logic op_is_4byte(input byte_t op);
		case (op)
			OP_READ4, OP_FAST4, OP_DOUT4, OP_QOUT4, OP_DIO4, OP_QIO4: op_is_4byte = 1'b1;
			default: op_is_4byte = 1'b0;
		endcase
	endfunction : op_is_4byte

	// Address is serial except for the dual and quad I/O reads
	function automatic byte_t addr_cycles(input idx_t cmd, input logic four);
		byte_t bits;
		bits = four ? ADDR4_BITS : ADDR3_BITS;
		if (cmd == CMD_DIO)
			addr_cycles = bits >> SHIFT_DUAL;
		else if (cmd == CMD_QIO)
			addr_cycles = bits >> SHIFT_QUAD;
		else
			addr_cycles = bits;
	endfunction : addr_cycles

endpackage : sdr_lat_pkg

/* File: rtl/lat_if.sv */
// Purpose: Carries one latency table lookup between its user and the table
// Assumes: Lookup is purely combinational
// Notes:   One instance per clock domain
`timescale 1ns/100ps
interface lat_if;
	sdr_lat_pkg::idx_t  row;
	sdr_lat_pkg::idx_t  cmd;
	sdr_lat_pkg::byte_t freq;
	sdr_lat_pkg::code_t code;
	sdr_lat_pkg::byte_t mode;
	sdr_lat_pkg::byte_t dummy;
	logic               supported;

	modport rom  (input row, input cmd, output freq, output code, output mode, output dummy, output supported);
	modport user (output row, output cmd, input freq, input code, input mode, input dummy, input supported);
endinterface : lat_if

/* File: rtl/latency_rom.sv */
// Purpose: Looks up band limit, latency code, mode and dummy counts for one band and command
// Assumes: Row and command indices come from the package enumerations
// Notes:   Out-of-range indices answer as unsupported
`timescale 1ns/100ps
module latency_rom (
	lat_if.rom t
);
	always_comb begin
		t.freq  = sdr_lat_pkg::UNSUPPORTED;
		t.code  = sdr_lat_pkg::code_t'(0);
		t.mode  = sdr_lat_pkg::UNSUPPORTED;
		t.dummy = sdr_lat_pkg::UNSUPPORTED;
		if (int'(t.row) < sdr_lat_pkg::ROWS) begin
			t.freq = sdr_lat_pkg::FREQ_MHZ[t.row];
			t.code = sdr_lat_pkg::ROW_CODE[t.row];
			if (int'(t.cmd) < sdr_lat_pkg::CMDS) begin
				t.mode  = sdr_lat_pkg::MODE_TBL[t.row][t.cmd];
				t.dummy = sdr_lat_pkg::DUMMY_TBL[t.row][t.cmd];
			end
		end
		t.supported = (t.mode != sdr_lat_pkg::UNSUPPORTED);
	end
endmodule : latency_rom

/* File: rtl/sync3.sv */
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Multi-bit input is quasi-static while it crosses
// Notes:   Output follows only when the second and third stages agree
`timescale 1ns/100ps
module sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout_q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} sync_s;

	sync_s st_q;
	sync_s st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3)
			st_d.out = st_q.s3;
		if (rst)
			st_d = '0;
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	assign dout_q = st_q.out;
endmodule : sync3

/* File: rtl/sdr_read_latency_select.sv */
// Purpose: Selects mode and dummy cycles for each single-data-rate read and marks unsupported reads
// Assumes: Serial clock stops outside frames; chip select high ends a frame at once
// Notes:   Latency code and high-band select must be stable during a frame
//
// Notes on behaviour
// - Lowest band reaches 50 MHz and is used only at or below that rate.
// - Code 11b: serial reads none; dual I/O 4 mode; quad I/O 2 mode 1 dummy.
// - Code 00b to 80 MHz: 8 dummy; dual I/O 4/0; quad I/O 2/4.
// - Code 01b to 90 MHz: 8 dummy; dual I/O 4/1; quad I/O 2/4.
// - Code 10b to 104 MHz: 8 dummy; dual I/O 4/2; quad I/O 2/5.
// - Top band is 133 MHz with code 10b; limits held in binary MHz.
// - At 133 MHz only fast read works, 0 mode and 8 dummy cycles.
`timescale 1ns/100ps
module sdr_read_latency_select (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic [1:0]         latency_code,
	input  wire logic               high_band,
	input  wire logic [2:0]         query_row,
	input  wire logic [2:0]         query_cmd,
	output logic      [7:0]         q_freq_q,
	output logic      [1:0]         q_code_q,
	output logic      [7:0]         q_mode_q,
	output logic      [7:0]         q_dummy_q,
	output logic                    q_supported_q,
	input  wire logic               sck,
	input  wire logic               cs_n,
	input  wire logic               si,
	output logic                    data_phase_q,
	output logic                    rd_done_q,
	output logic      [2:0]         rd_cmd_q,
	output logic      [7:0]         rd_mode_q,
	output logic      [7:0]         rd_dummy_q,
	output logic                    rd_unsup_q
);
	typedef struct packed {
		sdr_lat_pkg::code_t code;
		logic               hb;
		sdr_lat_pkg::byte_t freq;
		sdr_lat_pkg::code_t qcode;
		sdr_lat_pkg::byte_t mode;
		sdr_lat_pkg::byte_t dummy;
		logic               supported;
		logic               tog_seen;
		logic               done;
		sdr_lat_pkg::idx_t  rcmd;
		sdr_lat_pkg::byte_t rmode;
		sdr_lat_pkg::byte_t rdummy;
		logic               runsup;
	} core_s;

	typedef struct packed {
		sdr_lat_pkg::link_state_e state;
		sdr_lat_pkg::idx_t        bitcnt;
		logic [6:0]               shift;
		sdr_lat_pkg::byte_t       cnt;
		logic                     data;
	} link_s;

	// Result of the last decoded read, handed to the core domain with a toggle
	typedef struct packed {
		logic               tog;
		sdr_lat_pkg::idx_t  cmd;
		sdr_lat_pkg::byte_t mode;
		sdr_lat_pkg::byte_t dummy;
		logic               unsup;
	} event_s;

	core_s  cq;
	core_s  cd;
	link_s  lq;
	link_s  ld;
	event_s eq;
	event_s ed;

	logic               tog_s;
	logic [2:0]         cfg_s;
	sdr_lat_pkg::byte_t op_full;

	lat_if qry ();
	lat_if lnk ();

	latency_rom u_query_rom (
		.t (qry)
	);

	latency_rom u_link_rom (
		.t (lnk)
	);

	// Core domain lookup on the query port
	assign qry.row = query_row;
	assign qry.cmd = query_cmd;

	sync3 #(
		.WIDTH (1)
	) u_tog_sync (
		.clk    (clk),
		.rst    (rst),
		.din    (eq.tog),
		.dout_q (tog_s)
	);

	always_comb begin
		cd           = cq;
		cd.code      = latency_code;
		cd.hb        = high_band;
		cd.freq      = qry.freq;
		cd.qcode     = qry.code;
		cd.mode      = qry.mode;
		cd.dummy     = qry.dummy;
		cd.supported = qry.supported;
		cd.done      = 1'b0;
		// Event word is stable here: it only moves together with the toggle
		if (tog_s != cq.tog_seen) begin
			cd.tog_seen = tog_s;
			cd.done     = 1'b1;
			cd.rcmd     = eq.cmd;
			cd.rmode    = eq.mode;
			cd.rdummy   = eq.dummy;
			cd.runsup   = eq.unsup;
		end
		if (rst)
			cd = '0;
	end

	always_ff @(posedge clk) begin
		cq <= cd;
	end

	// Configuration crosses as a quasi-static word; opcode time covers the settling
	sync3 #(
		.WIDTH (3)
	) u_cfg_sync (
		.clk    (sck),
		.rst    (1'b0),
		.din    ({cq.hb, cq.code}),
		.dout_q (cfg_s)
	);

	assign op_full = {lq.shift, si};
	assign lnk.row = sdr_lat_pkg::code_to_row(cfg_s[1:0], cfg_s[2]);
	assign lnk.cmd = sdr_lat_pkg::decode_op(op_full);

	always_comb begin
		ld = lq;
		ed = eq;
		case (lq.state)
			sdr_lat_pkg::L_OPCODE: begin
				ld.shift  = op_full[6:0];
				ld.bitcnt = sdr_lat_pkg::idx_t'(lq.bitcnt + 3'h1);
				if (lq.bitcnt == sdr_lat_pkg::OP_LAST_BIT) begin
					if (lnk.cmd == sdr_lat_pkg::CMD_NONE) begin
						ld.state = sdr_lat_pkg::L_IGNORE;
					end else begin
						ed.tog   = ~eq.tog;
						ed.cmd   = lnk.cmd;
						ed.mode  = lnk.mode;
						ed.dummy = lnk.dummy;
						ed.unsup = ~lnk.supported;
						if (lnk.supported) begin
							ld.state = sdr_lat_pkg::L_LAT;
							// Address, mode and dummy cycles before data
							ld.cnt   = sdr_lat_pkg::byte_t'(
								sdr_lat_pkg::addr_cycles(lnk.cmd, sdr_lat_pkg::op_is_4byte(op_full))
								+ lnk.mode + lnk.dummy);
						end else begin
							ld.state = sdr_lat_pkg::L_IGNORE;
						end
					end
				end
			end
			sdr_lat_pkg::L_LAT: begin
				ld.cnt = sdr_lat_pkg::byte_t'(lq.cnt - 8'h01);
				if (lq.cnt == 8'h01) begin
					ld.state = sdr_lat_pkg::L_DATA;
					ld.data  = 1'b1;
				end
			end
			sdr_lat_pkg::L_DATA: begin
				ld.data = 1'b1;
			end
			sdr_lat_pkg::L_IGNORE: begin
				ld.data = 1'b0;
			end
			default: begin
				ld.state = sdr_lat_pkg::L_IGNORE;
			end
		endcase
	end

	// Frame state ends with chip select, which may come without any further clock edge
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n)
			lq <= '{state: sdr_lat_pkg::L_OPCODE, bitcnt: '0, shift: '0, cnt: '0, data: 1'b0};
		else
			lq <= ld;
	end

	// Event word survives frame ends; only the core reset clears it
	always_ff @(posedge sck or posedge rst) begin
		if (rst)
			eq <= '0;
		else
			eq <= ed;
	end

	assign q_freq_q      = cq.freq;
	assign q_code_q      = cq.qcode;
	assign q_mode_q      = cq.mode;
	assign q_dummy_q     = cq.dummy;
	assign q_supported_q = cq.supported;
	assign data_phase_q  = lq.data;
	assign rd_done_q     = cq.done;
	assign rd_cmd_q      = cq.rcmd;
	assign rd_mode_q     = cq.rmode;
	assign rd_dummy_q    = cq.rdummy;
	assign rd_unsup_q    = cq.runsup;

	property p_row50;
		@(posedge clk) disable iff (rst)
		(query_row == 3'h0) |=> (q_freq_q == 8'h32 && q_code_q == 2'h3);
	endproperty
	a_row50: assert property (p_row50) else $error("lowest band limit or code wrong");

	property p_code11;
		@(posedge clk) disable iff (rst)
		(query_row == 3'h0 && query_cmd == 3'h5) |=> (q_mode_q == 8'h02 && q_dummy_q == 8'h01 && q_supported_q);
	endproperty
	a_code11: assert property (p_code11) else $error("quad I/O counts wrong in lowest band");

	property p_code00;
		@(posedge clk) disable iff (rst)
		(query_row == 3'h1 && query_cmd == 3'h2) |=> (q_mode_q == 8'h00 && q_dummy_q == 8'h08);
	endproperty
	a_code00: assert property (p_code00) else $error("dual out counts wrong at 80 MHz");

	property p_code01;
		@(posedge clk) disable iff (rst)
		(query_row == 3'h2 && query_cmd == 3'h4) |=> (q_mode_q == 8'h04 && q_dummy_q == 8'h01);
	endproperty
	a_code01: assert property (p_code01) else $error("dual I/O counts wrong at 90 MHz");

	property p_code10;
		@(posedge clk) disable iff (rst)
		(query_row == 3'h3 && query_cmd == 3'h5) |=> (q_mode_q == 8'h02 && q_dummy_q == 8'h05 && q_code_q == 2'h2);
	endproperty
	a_code10: assert property (p_code10) else $error("quad I/O counts wrong at 104 MHz");

	property p_plain_read;
		@(posedge clk) disable iff (rst)
		(query_cmd == 3'h0 && query_row != 3'h0) |=> (!q_supported_q && q_mode_q == 8'hFF && q_dummy_q == 8'hFF);
	endproperty
	a_plain_read: assert property (p_plain_read) else $error("plain read not marked unsupported");

	property p_top_band;
		@(posedge clk) disable iff (rst)
		(query_row == 3'h4) |=> (q_freq_q == 8'h85 && q_code_q == 2'h2);
	endproperty
	a_top_band: assert property (p_top_band) else $error("top band limit or code wrong");

	property p_top_only_fast;
		@(posedge clk) disable iff (rst)
		(query_row == 3'h4) |=> (q_supported_q == ($past(query_cmd) == 3'h1)) &&
			(!q_supported_q || (q_mode_q == 8'h00 && q_dummy_q == 8'h08));
	endproperty
	a_top_only_fast: assert property (p_top_only_fast) else $error("top band support wrong");

	sequence s_last_wait;
		lq.state == sdr_lat_pkg::L_LAT && lq.cnt == 8'h01;
	endsequence

	sequence s_data_held;
		data_phase_q [*2];
	endsequence

	property p_data_start;
		@(posedge sck) disable iff (cs_n)
		s_last_wait |=> s_data_held;
	endproperty
	a_data_start: assert property (p_data_start) else $error("data phase not entered after wait");

	property p_no_early_data;
		@(posedge sck) disable iff (cs_n)
		$rose(data_phase_q) |-> $past(lq.state == sdr_lat_pkg::L_LAT && lq.cnt == 8'h01);
	endproperty
	a_no_early_data: assert property (p_no_early_data) else $error("data phase began early");

	property p_report;
		@(posedge clk) disable iff (rst)
		rd_done_q |-> (rd_unsup_q == (rd_mode_q == 8'hFF)) ##1 !rd_done_q;
	endproperty
	a_report: assert property (p_report) else $error("read report inconsistent");

endmodule : sdr_read_latency_select

/* File: tb/spi_host_model.sv */
// Purpose: Behavioural serial host that frames reads towards the latency selector
// Assumes: Mode 0 clocking; sck period 12 ns, unrelated to the core clock
// Notes:   sck stands still between frames; si is never left holding a stale bit
`timescale 1ns/100ps
module spi_host_model (
	output logic sck,
	output logic cs_n,
	output logic si
);
	// Chip select rises once after time zero so the frame logic sees a real clearing edge
	initial begin
		sck  = 1'b0;
		cs_n = 1'b0;
		si   = 1'b1;
		#1 cs_n = 1'b1;
	end

	task automatic start;
		#5 cs_n = 1'b0;
	endtask : start

	// Opcode goes out most significant bit first
	task automatic opcode(input logic [7:0] op);
		for (int i = 7; i >= 0; i--) begin
			si = op[i];
			#6 sck = 1'b1;
			#6 sck = 1'b0;
		end
	endtask : opcode

	// Address, mode and wait edges; si toggles so nothing is mistaken for held data
	task automatic pulse(input int n);
		repeat (n) begin
			si = ~si;
			#6 sck = 1'b1;
			#6 sck = 1'b0;
		end
	endtask : pulse

	// Caller counts exactly the listed wait before expecting data
	task automatic stop;
		#6 cs_n = 1'b1;
		si = ~si;
	endtask : stop
endmodule : spi_host_model

/* File: tb/sdr_read_latency_select_tb_top.sv */
// Purpose: Self-checking bench for the read latency selector, table port and serial link
// Assumes: Design answers table queries one clk after sampling
// Notes:   Link runs faster than the low bands allow; the design never sees the rate
`timescale 1ns/100ps
module sdr_read_latency_select_tb_top;
	logic       clk          = 1'b0;
	logic       rst          = 1'b0;
	logic [1:0] latency_code = 2'h3;
	logic       high_band    = 1'b0;
	logic [2:0] query_row    = 3'h0;
	logic [2:0] query_cmd    = 3'h0;
	logic       sck, cs_n, si;
	logic [7:0] q_freq_q, q_mode_q, q_dummy_q, rd_mode_q, rd_dummy_q;
	logic [1:0] q_code_q;
	logic       q_supported_q, data_phase_q, rd_done_q, rd_unsup_q;
	logic [2:0] rd_cmd_q;
	int         bad_count    = 0;
	int         total_checks = 0;
	int         done_seen    = 0;
	// Rows 50..133 MHz; columns read, fast, dual out, quad out, dual I/O, quad I/O
	localparam logic [47:0] MODE_EXP [5] = '{48'h000000000402, 48'hFF0000000402, 48'hFF0000000402,
		48'hFF0000000402, 48'hFF00FFFFFFFF};
	localparam logic [47:0] DUMMY_EXP [5] = '{48'h000000000001, 48'hFF0808080004, 48'hFF0808080104,
		48'hFF0808080205, 48'hFF08FFFFFFFF};
	localparam logic [39:0] FREQ_EXP = 40'h32505A6885;
	localparam logic [9:0]  CODE_EXP = 10'h31A;

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		if (rd_done_q === 1'b1) begin
			done_seen <= done_seen + 1;
		end
	end

	sdr_read_latency_select u_sdr_read_latency_select (
		.clk(clk), .rst(rst), .latency_code(latency_code), .high_band(high_band),
		.query_row(query_row), .query_cmd(query_cmd), .q_freq_q(q_freq_q), .q_code_q(q_code_q),
		.q_mode_q(q_mode_q), .q_dummy_q(q_dummy_q), .q_supported_q(q_supported_q),
		.sck(sck), .cs_n(cs_n), .si(si), .data_phase_q(data_phase_q), .rd_done_q(rd_done_q),
		.rd_cmd_q(rd_cmd_q), .rd_mode_q(rd_mode_q), .rd_dummy_q(rd_dummy_q), .rd_unsup_q(rd_unsup_q)
	);

	spi_host_model u_spi_host_model (.sck(sck), .cs_n(cs_n), .si(si));

	function automatic logic [7:0] pick(input logic [47:0] row, input int c);
		pick = row[47-8*c -: 8];
	endfunction : pick

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic conclude;
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	task automatic query(input int r, input int c);
		@(posedge clk);
		#2;
		query_row = r[2:0];
		query_cmd = c[2:0];
		@(posedge clk);
		#1;
	endtask : query

	task automatic test_table;
		logic [7:0] m;
		for (int r = 0; r < 5; r++) begin
			for (int c = 0; c < 6; c++) begin
				m = pick(MODE_EXP[r], c);
				query(r, c);
				cmp(q_freq_q, FREQ_EXP[39-8*r -: 8]);
				cmp({6'h00, q_code_q}, {6'h00, CODE_EXP[9-2*r -: 2]});
				cmp(q_mode_q, m);
				cmp(q_dummy_q, pick(DUMMY_EXP[r], c));
				cmp({7'h00, q_supported_q}, {7'h00, m != 8'hFF});
			end
		end
		query(5, 1);
		cmp(q_freq_q, 8'hFF);
		cmp(q_mode_q, 8'hFF);
		cmp({7'h00, q_supported_q}, 8'h00);
		query(0, 6);
		cmp(q_dummy_q, 8'hFF);
		cmp({7'h00, q_supported_q}, 8'h00);
		$display("test_table finished");
	endtask : test_table

	// One read frame; an unsupported or unknown read must never reach a data phase
	task automatic link_case(input logic [1:0] code, input logic hb, input logic [7:0] op, input int c,
		input int r, input logic four);
		logic [7:0] m;
		logic [7:0] d;
		int         w;
		int         seen;
		m = (c < 6) ? pick(MODE_EXP[r], c) : 8'hFF;
		d = (c < 6) ? pick(DUMMY_EXP[r], c) : 8'hFF;
		w = four ? 32 : 24;
		if (c == 4) begin
			w = w / 2;
		end
		if (c == 5) begin
			w = w / 4;
		end
		w = w + m + d;
		@(posedge clk);
		#2;
		latency_code = code;
		high_band    = hb;
		repeat (4) @(posedge clk);
		seen = done_seen;
		u_spi_host_model.start();
		u_spi_host_model.opcode(op);
		if (m != 8'hFF) begin
			u_spi_host_model.pulse(w - 1);
			cmp({7'h00, data_phase_q}, 8'h00);
			u_spi_host_model.pulse(1);
			cmp({7'h00, data_phase_q}, 8'h01);
			// Two more edges so the data phase is seen to hold inside the frame
			u_spi_host_model.pulse(2);
			cmp({7'h00, data_phase_q}, 8'h01);
		end else begin
			u_spi_host_model.pulse(48);
			cmp({7'h00, data_phase_q}, 8'h00);
		end
		u_spi_host_model.stop();
		repeat (8) @(posedge clk);
		cmp(8'(done_seen - seen), (c < 6) ? 8'h01 : 8'h00);
		if (c < 6) begin
			cmp({5'h00, rd_cmd_q}, 8'(c));
			cmp(rd_mode_q, m);
			cmp(rd_dummy_q, d);
			cmp({7'h00, rd_unsup_q}, {7'h00, m == 8'hFF});
		end
		$display("link_case op=%h finished", op);
	endtask : link_case

	// Reset rises after time zero so the serial-side event word gets its clearing edge
	initial begin
		#1 rst = 1'b1;
		repeat (8) @(posedge clk);
		#2 rst = 1'b0;
		test_table();
		link_case(2'h3, 1'b0, 8'hEB, 5, 0, 1'b0);
		link_case(2'h3, 1'b0, 8'h13, 0, 0, 1'b1);
		// Plain read above the lowest band is issued on purpose to see it refused
		link_case(2'h0, 1'b0, 8'h03, 0, 1, 1'b0);
		link_case(2'h0, 1'b0, 8'hBB, 4, 1, 1'b0);
		link_case(2'h1, 1'b0, 8'hBC, 4, 2, 1'b1);
		link_case(2'h2, 1'b0, 8'h6B, 3, 3, 1'b0);
		link_case(2'h2, 1'b1, 8'h0C, 1, 4, 1'b1);
		link_case(2'h2, 1'b1, 8'h3B, 2, 4, 1'b0);
		link_case(2'h0, 1'b0, 8'h9F, 7, 1, 1'b0);
		conclude();
	end

	// Whole run needs about 9.5 us; a hang is cut well beyond that
	initial begin
		#100000;
		$display("watchdog expired");
		bad_count++;
		conclude();
	end
endmodule : sdr_read_latency_select_tb_top
